// file: icp_core.sv
// Interrupt controller: request and mask flags, priority, vector to the core
//
// Behaviour
// - Non-maskable request is taken regardless of masks and ranks above all.
// - The non-maskable request or any unmasked maskable request raises the standby release.
// - Watchdog overflow in first watchdog mode is the non-maskable source, vector 0004H.
// - Watchdog overflow in interval mode is maskable at level 0.
// - Sixteen maskable sources, five external and eleven internal, each masked.
// - Lowest pending priority number wins; 0 highest, 15 lowest.
// - Pin edge sources at levels 1 to 4, vectors 0006H to 000CH.
// - Serial receive and 3-wire done share level 5, one flag, vector 000EH.
// - Serial transmit, watch timer, watch interval at levels 6 to 8.
// - Three 8-bit timers and the 16-bit timer at levels 9 to 12.
// - Key return, A/D done and comparator at levels 13 to 15.
// - Flag sets on source or write of 1; clears on write, acknowledge, reset.
// - Reset clears both request flag registers.
// - Reset sets both mask registers; mask 0 enables, mask 1 disables.
// - Acknowledge clears the served flag before the routine runs.
// - Watchdog flag usable only in interval mode; else held at 0.
// - Watchdog mask bit reads undefined in watchdog modes.
// - Output-mode level change on a shared pin sets its flag.
// - Flag and mask registers take single-bit and whole-byte writes.
// - Maskable source served only while flag is 1 and mask is 0.
// - Vectored maskable interrupt only while the global enable is set.
`timescale 1ns/100ps
`default_nettype none
module icp_core (
  input wire logic clk,
  input wire logic rstn,
  input wire icp_pkg::icp_wdt_mode_t wdt_mode,
  input wire logic watchdog_overflow_irq,
  input wire logic pin_edge_irq_0,
  input wire logic pin_edge_irq_1,
  input wire logic pin_edge_irq_2,
  input wire logic pin_edge_irq_3,
  input wire logic serial_rx_done_irq,
  input wire logic serial_3wire_done_irq,
  input wire logic serial_tx_done_irq,
  input wire logic watch_timer_irq,
  input wire logic watch_interval_irq,
  input wire logic timer8_a_match_irq,
  input wire logic timer8_b_match_irq,
  input wire logic timer8_c_match_irq,
  input wire logic timer16_match_irq,
  input wire logic key_return_irq,
  input wire logic adc_done_irq,
  input wire logic comparator_irq,
  input wire logic global_interrupt_enable,
  input wire logic cpu_ack,
  input wire logic [1:0] sfr_sel,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_idx,
  input wire logic sfr_bit_val,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic irq_req,
  output logic nmi_req,
  output logic [icp_pkg::VEC_W-1:0] irq_vector,
  output logic standby_release
);
  import icp_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte-wide write or single-bit read-modify-write of one register
  function automatic logic [7:0] sfr_merge(
    input logic [7:0] old,
    input logic byte_wr,
    input logic bit_wr,
    input logic [2:0] idx,
    input logic val,
    input logic [7:0] wdata
  );
    logic [7:0] res;
    res = old;
    if (byte_wr) begin
      res = wdata;
    end else if (bit_wr) begin
      res[idx] = val;
    end
    return res;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [NUM_SRC-1:0] flags_reg;
  logic [NUM_SRC-1:0] flags_next;
  logic [NUM_SRC-1:0] mask_reg;
  logic [NUM_SRC-1:0] mask_next;
  logic [IDX_W-1:0] sel_idx_reg;
  logic [NUM_SRC-1:0] src_vec;
  logic nmi_set;
  logic ack_nmi;
  logic ack_mask;
  logic wdt_interval;
  logic any_wr;

  icp_res_if res_bus ();

  icp_prio #(
    .N(NUM_SRC)
  ) u_prio (
    .res(res_bus.resolver)
  );

  // ----------------------------------------
  // Source mapping
  // ----------------------------------------
  // Watchdog routes to the maskable level 0 only in interval use
  assign wdt_interval = (wdt_mode == WDT_INTERVAL);
  assign nmi_set = watchdog_overflow_irq && (wdt_mode == WDT_MODE1);
  assign src_vec[SRC_WDT] = watchdog_overflow_irq && wdt_interval;
  assign src_vec[1] = pin_edge_irq_0;
  assign src_vec[2] = pin_edge_irq_1;
  assign src_vec[3] = pin_edge_irq_2;
  assign src_vec[4] = pin_edge_irq_3;
  assign src_vec[SRC_SERIAL_RX] = serial_rx_done_irq | serial_3wire_done_irq;
  assign src_vec[6] = serial_tx_done_irq;
  assign src_vec[7] = watch_timer_irq;
  assign src_vec[8] = watch_interval_irq;
  assign src_vec[9] = timer8_a_match_irq;
  assign src_vec[10] = timer8_b_match_irq;
  assign src_vec[11] = timer8_c_match_irq;
  assign src_vec[12] = timer16_match_irq;
  assign src_vec[13] = key_return_irq;
  assign src_vec[14] = adc_done_irq;
  assign src_vec[15] = comparator_irq;

  // ----------------------------------------
  // Acknowledge decode
  // ----------------------------------------
  // The non-maskable request always takes the acknowledge first
  assign ack_nmi = cpu_ack && nmi_req;
  assign ack_mask = cpu_ack && !nmi_req && irq_req;
  assign any_wr = sfr_wr || sfr_bit_wr;

  // Only requested and unmasked sources compete
  assign res_bus.req = flags_reg & ~mask_reg;

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  // Order matters: software, then acknowledge, then sources, so a set wins
  always_comb begin
    flags_next = flags_reg;
    if (any_wr && sfr_sel == SEL_FLAGS0) begin
      flags_next[7:0] = sfr_merge(flags_reg[7:0], sfr_wr, sfr_bit_wr, sfr_bit_idx, sfr_bit_val, sfr_wdata);
    end else if (any_wr && sfr_sel == SEL_FLAGS1) begin
      flags_next[15:8] = sfr_merge(flags_reg[15:8], sfr_wr, sfr_bit_wr, sfr_bit_idx, sfr_bit_val, sfr_wdata);
    end
    if (ack_mask) begin
      flags_next[sel_idx_reg] = 1'b0;
    end
    flags_next = flags_next | src_vec;
    if (!wdt_interval) begin
      flags_next[SRC_WDT] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_reg <= {FLAG_RESET, FLAG_RESET};
    end else begin
      flags_reg <= flags_next;
    end
  end

  // ----------------------------------------
  // Mask flags
  // ----------------------------------------
  // Masks change only by software; hardware never touches them
  always_comb begin
    mask_next = mask_reg;
    if (any_wr && sfr_sel == SEL_MASK0) begin
      mask_next[7:0] = sfr_merge(mask_reg[7:0], sfr_wr, sfr_bit_wr, sfr_bit_idx, sfr_bit_val, sfr_wdata);
    end else if (any_wr && sfr_sel == SEL_MASK1) begin
      mask_next[15:8] = sfr_merge(mask_reg[15:8], sfr_wr, sfr_bit_wr, sfr_bit_idx, sfr_bit_val, sfr_wdata);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_reg <= {MASK_RESET, MASK_RESET};
    end else begin
      mask_reg <= mask_next;
    end
  end

  // ----------------------------------------
  // Non-maskable pending flag
  // ----------------------------------------
  // A second overflow during service re-arms the flag; the set wins over ack
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      nmi_req <= 1'b0;
    end else if (nmi_set) begin
      nmi_req <= 1'b1;
    end else if (ack_nmi) begin
      nmi_req <= 1'b0;
    end
  end

  // ----------------------------------------
  // Request and vector to the core
  // ----------------------------------------
  // Request drops for one cycle after an acknowledge so a stale winner is
  // never offered twice; the resolver sees the cleared flag next cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_req <= 1'b0;
      sel_idx_reg <= '0;
      irq_vector <= VEC_NMI;
    end else begin
      irq_req <= res_bus.valid && global_interrupt_enable && !cpu_ack;
      sel_idx_reg <= res_bus.idx;
      if (nmi_req) begin
        irq_vector <= VEC_NMI;
      end else begin
        irq_vector <= VEC_TABLE[res_bus.idx];
      end
    end
  end

  // ----------------------------------------
  // Standby release
  // ----------------------------------------
  // Wake on any unmasked pending source; the global enable is not needed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      standby_release <= 1'b0;
    end else begin
      standby_release <= res_bus.valid || nmi_req;
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  // One cycle of read latency; the watchdog mask bit is not qualified by mode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= FLAG_RESET;
    end else if (sfr_sel == SEL_FLAGS0) begin
      sfr_rdata <= flags_reg[7:0];
    end else if (sfr_sel == SEL_FLAGS1) begin
      sfr_rdata <= flags_reg[15:8];
    end else if (sfr_sel == SEL_MASK0) begin
      sfr_rdata <= mask_reg[7:0];
    end else begin
      sfr_rdata <= mask_reg[15:8];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  source_set_a: assert property (
    (src_vec != '0) |=> ((flags_reg & $past(src_vec)) == $past(src_vec))
  ) else $error("source event lost in request flags");

  nmi_arm_a: assert property (
    nmi_set |=> nmi_req
  ) else $error("watchdog overflow in mode 1 did not arm non-maskable request");

  nmi_vector_a: assert property (
    nmi_req |=> (irq_vector == VEC_NMI)
  ) else $error("non-maskable vector not presented");

  wdt_flag_a: assert property (
    !wdt_interval |=> !flags_reg[SRC_WDT]
  ) else $error("watchdog flag set outside interval mode");

  ack_clear_a: assert property (
    (ack_mask && !any_wr && (src_vec == '0)) |=> !flags_reg[$past(sel_idx_reg)]
  ) else $error("acknowledged flag not cleared");

  enable_gate_a: assert property (
    irq_req |-> ($past(global_interrupt_enable) && !$past(cpu_ack))
  ) else $error("maskable request offered while disabled");

  masked_quiet_a: assert property (
    ((flags_reg & ~mask_reg) == '0) |=> !irq_req
  ) else $error("request raised with nothing unmasked");

  lowest_wins_a: assert property (
    res_bus.valid |-> (res_bus.req[res_bus.idx]
      && ((res_bus.req & ((16'h0001 << res_bus.idx) - 16'h0001)) == '0))
  ) else $error("resolver did not pick the lowest level");

  wake_a: assert property (
    (nmi_req || res_bus.valid) |=> standby_release
  ) else $error("standby release missing for a pending request");

  mask_byte_a: assert property (
    (sfr_wr && sfr_sel == SEL_MASK0) |=> (mask_reg[7:0] == $past(sfr_wdata))
  ) else $error("byte write to mask register 0 not stored");

  vec_map_a: assert property (
    (!nmi_req && res_bus.valid) |=> (irq_vector == VEC_TABLE[$past(res_bus.idx)])
  ) else $error("vector does not match winning level");

endmodule
`default_nettype wire

// file: icp_cpu_model.sv
// Stand-in for the processor core that takes requests from the controller
`timescale 1ns/100ps
`default_nettype none
module icp_cpu_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ack_en,
  input wire logic ie_set,
  input wire logic irq_req,
  input wire logic nmi_req,
  input wire logic [15:0] irq_vector,
  output logic cpu_ack,
  output logic global_interrupt_enable,
  output logic [15:0] last_vec,
  output logic [7:0] ack_count
);
  // ----------------------------------------
  // Acknowledge
  // ----------------------------------------
  // One-cycle ack; vector taken at the edge that samples the ack
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_ack <= 1'b0;
      last_vec <= 16'h0000;
      ack_count <= 8'h00;
    end else if (cpu_ack) begin
      cpu_ack <= 1'b0;
      last_vec <= irq_vector;
      ack_count <= ack_count + 8'h01;
    end else if (ack_en && (nmi_req || (irq_req && global_interrupt_enable))) begin
      cpu_ack <= 1'b1;
    end
  end

  // Enable flag drops on every acknowledge not met by ie_set, as the status word is stacked
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      global_interrupt_enable <= 1'b0;
    end else if (ie_set) begin
      global_interrupt_enable <= 1'b1;
    end else if (cpu_ack) begin
      global_interrupt_enable <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: icp_pkg.sv
// Shared constants and types for the interrupt controller
package icp_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_SRC = 16;
  localparam int IDX_W = 4;
  localparam int VEC_W = 16;

  // ----------------------------------------
  // Register select codes on the processor side
  // ----------------------------------------
  localparam logic [1:0] SEL_FLAGS0 = 2'h0;
  localparam logic [1:0] SEL_FLAGS1 = 2'h1;
  localparam logic [1:0] SEL_MASK0 = 2'h2;
  localparam logic [1:0] SEL_MASK1 = 2'h3;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'hFF;

  // ----------------------------------------
  // Source positions (bit index equals priority level)
  // ----------------------------------------
  localparam int SRC_WDT = 0;
  localparam int SRC_SERIAL_RX = 5;

  // ----------------------------------------
  // Vector addresses
  // ----------------------------------------
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'h0004, 16'h0006, 16'h0008, 16'h000A,
    16'h000C, 16'h000E, 16'h0010, 16'h0012,
    16'h0014, 16'h0016, 16'h0018, 16'h001A,
    16'h001C, 16'h001E, 16'h0020, 16'h0022
  };

  // ----------------------------------------
  // Watchdog operating mode, one-hot
  // ----------------------------------------
  typedef enum logic [2:0] {
    WDT_INTERVAL = 3'b001,
    WDT_MODE1 = 3'b010,
    WDT_MODE2 = 3'b100
  } icp_wdt_mode_t;

endpackage

// file: icp_prio.sv
// Fixed-priority resolver: lowest pending index wins
`timescale 1ns/100ps
`default_nettype none
module icp_prio #(
  parameter int N = 16
) (
  icp_res_if.resolver res
);
  import icp_pkg::*;

  // ----------------------------------------
  // Resolution
  // ----------------------------------------
  // Scan from the highest level downward so the lowest level, found last, wins
  always_comb begin
    res.valid = 1'b0;
    res.idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (res.req[i]) begin
        res.valid = 1'b1;
        res.idx = IDX_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

// file: icp_res_if.sv
// Carrier between the controller core and its priority resolver
`timescale 1ns/100ps
`default_nettype none
interface icp_res_if;
  logic [15:0] req;
  logic valid;
  logic [3:0] idx;
  modport core (output req, input valid, input idx);
  modport resolver (input req, output valid, output idx);
endinterface
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import icp_pkg::*;
  typedef struct {logic [16:0] src; logic [15:0] vec;} icp_row_t;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  icp_wdt_mode_t wdt_mode = WDT_INTERVAL;
  logic [16:0] src = '0;
  logic ie_set = 1'b0;
  logic ack_en = 1'b1;
  logic [1:0] sfr_sel = 2'h0;
  logic sfr_wr = 1'b0;
  logic sfr_bit_wr = 1'b0;
  logic [2:0] sfr_bit_idx = 3'h0;
  logic sfr_bit_val = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic irq_req, nmi_req, standby_release, cpu_ack, gie;
  logic [15:0] irq_vector, last_vec;
  logic [7:0] ack_count;
  icp_row_t rows [19];
  int fail_count = 0;
  int comparisons = 0;

  // ----------------------------------------
  // Clock and parts
  // ----------------------------------------
  always #2 clk = ~clk;

  icp_core dut_u (.clk(clk), .rstn(rstn), .wdt_mode(wdt_mode), .watchdog_overflow_irq(src[0]),
    .pin_edge_irq_0(src[1]), .pin_edge_irq_1(src[2]), .pin_edge_irq_2(src[3]), .pin_edge_irq_3(src[4]),
    .serial_rx_done_irq(src[5]), .serial_3wire_done_irq(src[16]), .serial_tx_done_irq(src[6]),
    .watch_timer_irq(src[7]), .watch_interval_irq(src[8]), .timer8_a_match_irq(src[9]),
    .timer8_b_match_irq(src[10]), .timer8_c_match_irq(src[11]), .timer16_match_irq(src[12]),
    .key_return_irq(src[13]), .adc_done_irq(src[14]), .comparator_irq(src[15]),
    .global_interrupt_enable(gie), .cpu_ack(cpu_ack), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_idx(sfr_bit_idx), .sfr_bit_val(sfr_bit_val), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .irq_req(irq_req), .nmi_req(nmi_req), .irq_vector(irq_vector),
    .standby_release(standby_release));

  icp_cpu_model cpu_u (.clk(clk), .rstn(rstn), .ack_en(ack_en), .ie_set(ie_set), .irq_req(irq_req),
    .nmi_req(nmi_req), .irq_vector(irq_vector), .cpu_ack(cpu_ack), .global_interrupt_enable(gie),
    .last_vec(last_vec), .ack_count(ack_count));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Strobes drop for a full cycle so no signal is driven twice in one step
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    sfr_sel <= sel;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clk);
    sfr_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bitwr(input logic [1:0] sel, input logic [2:0] idx, input logic v);
    sfr_sel <= sel;
    sfr_bit_idx <= idx;
    sfr_bit_val <= v;
    sfr_bit_wr <= 1'b1;
    @(posedge clk);
    sfr_bit_wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data lags the select by one edge; sampled mid-cycle
  task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
    sfr_sel <= sel;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({8'h00, sfr_rdata}, {8'h00, exp});
    @(posedge clk);
  endtask

  task automatic pulse(input logic [16:0] v, input logic ie);
    src <= v;
    ie_set <= ie;
    @(posedge clk);
    src <= '0;
    ie_set <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_ack(input logic [7:0] n0);
    int k;
    k = 0;
    while (ack_count === n0 && k < 20) begin
      @(negedge clk);
      k++;
    end
    chk({8'h00, ack_count}, {8'h00, n0 + 8'h01});
    @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    // Single sources give the table, combinations test the priority order
    for (int i = 0; i < 16; i++) rows[i] = '{17'h1 << i, 16'h0004 + 16'(2 * i)};
    rows[16] = '{17'h10000, 16'h000E};
    rows[17] = '{17'h08200, 16'h0016};
    rows[18] = '{17'h1FFFE, 16'h0006};
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    wr(SEL_MASK0, 8'h00);
    wr(SEL_MASK1, 8'h00);
    for (int i = 0; i < 19; i++) begin
      automatic logic [7:0] n = ack_count;
      pulse(rows[i].src, 1'b1);
      wait_ack(n);
      chk(last_vec, rows[i].vec);
      wr(SEL_FLAGS0, 8'h00);
      wr(SEL_FLAGS1, 8'h00);
    end
    // Masked source keeps its flag but is not offered
    wr(SEL_MASK1, 8'hFF);
    pulse(17'h00200, 1'b1);
    repeat (3) @(posedge clk);
    chk({15'h0, irq_req}, 16'h0);
    chk({15'h0, standby_release}, 16'h0);
    rd(SEL_FLAGS1, 8'h02);
    bitwr(SEL_MASK1, 3'h1, 1'b0);
    wait_ack(ack_count);
    chk(last_vec, 16'h0016);
    rd(SEL_FLAGS1, 8'h00);
    // Enable low blocks the vector but still wakes the processor
    pulse(17'h00008, 1'b0);
    repeat (3) @(posedge clk);
    chk({15'h0, irq_req}, 16'h0);
    chk({15'h0, standby_release}, 16'h1);
    pulse(17'h0, 1'b1);
    wait_ack(ack_count);
    chk(last_vec, 16'h000A);
    wr(SEL_FLAGS0, 8'h00);
    // Watchdog mode 1: flag refused, overflow is non-maskable
    wdt_mode <= WDT_MODE1;
    wr(SEL_MASK0, 8'hFF);
    bitwr(SEL_FLAGS0, 3'h0, 1'b1);
    rd(SEL_FLAGS0, 8'h00);
    ack_en <= 1'b0;
    pulse(17'h00001, 1'b0);
    @(negedge clk);
    chk({15'h0, nmi_req}, 16'h1);
    chk({15'h0, standby_release}, 16'h1);
    chk(irq_vector, 16'h0004);
    @(posedge clk);
    ack_en <= 1'b1;
    wait_ack(ack_count);
    chk(last_vec, 16'h0004);
    // Watchdog mode 2: overflow raises neither the flag nor a non-maskable request
    wdt_mode <= WDT_MODE2;
    pulse(17'h00001, 1'b0);
    @(negedge clk);
    chk({15'h0, nmi_req}, 16'h0);
    @(posedge clk);
    rd(SEL_FLAGS0, 8'h00);
    // Mid-run reset restores the flag and mask values
    wdt_mode <= WDT_INTERVAL;
    wr(SEL_FLAGS1, 8'h5A);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(SEL_FLAGS0, 8'h00);
    rd(SEL_FLAGS1, 8'h00);
    rd(SEL_MASK0, 8'hFF);
    rd(SEL_MASK1, 8'hFF);
    end_of_test();
  end

  // Whole run needs well under 1000 cycles; this cuts a hang short
  initial begin
    #40000;
    fail_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
